// ==== acl_pkg.sv ====
package acl_pkg;
  localparam int unsigned NUM_PORTS = 6;
  localparam int unsigned ENTRIES = 16;
  localparam int unsigned TBL_DEPTH = NUM_PORTS * ENTRIES;
  localparam int unsigned ENTRY_W = 23;
  localparam int unsigned CNT_W = 11;
  localparam logic [2:0] LAST_PORT = 3'h5;
  // action field layout, filtering view
  localparam int unsigned F_PRIO_MODE_LO = 0;
  localparam int unsigned F_PRIO_LO = 2;
  localparam int unsigned F_REMARK_EN = 5;
  localparam int unsigned F_RV_LO = 6;
  localparam int unsigned F_MAP_MODE_LO = 9;
  // count view reuses bits 10:0 as the count value
  localparam int unsigned F_CNT_LO = 0;
  localparam int unsigned F_UNIT_SEL = 11;
  localparam int unsigned F_ALGO_SEL = 12;
  localparam int unsigned F_FWD_LO = 13;
  // matching field bits that decide count mode
  localparam int unsigned F_KIND_LO = 19;
  localparam int unsigned F_CSEL_LO = 21;
  localparam logic [1:0] PRIO_QOS = 2'h0;
  localparam logic [1:0] PRIO_IF_HIGHER = 2'h1;
  localparam logic [1:0] PRIO_IF_LOWER = 2'h2;
  localparam logic [1:0] PRIO_ALWAYS = 2'h3;
  localparam logic [1:0] MAP_KEEP = 2'h0;
  localparam logic [1:0] MAP_OR = 2'h1;
  localparam logic [1:0] MAP_AND = 2'h2;
  localparam logic [1:0] MAP_REPLACE = 2'h3;
  localparam logic [1:0] KIND_OFF = 2'h0;
  localparam logic [1:0] KIND_L2 = 2'h1;
  localparam logic [1:0] KIND_L3 = 2'h2;
  localparam logic [1:0] KIND_L4 = 2'h3;
  localparam logic [1:0] CSEL_COUNT = 2'h0;
  // register offsets
  localparam logic [11:0] OFS_PSTAT = 12'h000;
  localparam logic [11:0] OFS_PMASK = 12'h004;
  localparam logic [11:0] OFS_GSTAT = 12'h008;
  localparam logic [11:0] OFS_GMASK = 12'h00C;
  localparam logic [11:0] OFS_CNT_BASE = 12'h020;
  localparam logic [11:0] OFS_TABLE = 12'h100;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [22:0] TBL_RST = 23'h000000;
  localparam logic [10:0] CNT_RST = 11'h000;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned US_NS = 1000;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {ACL_CNT_IDLE, ACL_CNT_TIME, ACL_CNT_PKT} acl_cnt_e;
endpackage : acl_pkg

// ==== acl_timebase.sv ====
`timescale 1ns/1ns
module acl_timebase #(
  parameter int unsigned US_CYC = 10,
  parameter int unsigned MS_US = 1000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ticks
  output logic us_tick_o,
  output logic ms_tick_o
);
  logic [15:0] us_cnt_q, us_cnt_d, ms_cnt_q, ms_cnt_d;
  logic us_tick_q, us_tick_d, ms_tick_q, ms_tick_d;

  // ms is chained off the us tick so both stay phase-aligned
  always_comb begin
    us_cnt_d = us_cnt_q + 16'h0001;
    us_tick_d = 1'b0;
    ms_cnt_d = ms_cnt_q;
    ms_tick_d = 1'b0;
    if (us_cnt_q == 16'(US_CYC - 1)) begin
      us_cnt_d = 16'h0000;
      us_tick_d = 1'b1;
      if (ms_cnt_q == 16'(MS_US - 1)) begin
        ms_cnt_d = 16'h0000;
        ms_tick_d = 1'b1;
      end else begin
        ms_cnt_d = ms_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      us_cnt_q <= 16'h0000;
      ms_cnt_q <= 16'h0000;
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
    end else begin
      us_cnt_q <= us_cnt_d;
      ms_cnt_q <= ms_cnt_d;
      us_tick_q <= us_tick_d;
      ms_tick_q <= ms_tick_d;
    end
  end

  assign us_tick_o = us_tick_q;
  assign ms_tick_o = ms_tick_q;
endmodule : acl_timebase

// ==== acl_action_and_count_logic.sv ====
// Functional notes
// RL1: priority mode picks QoS or rule priority
// RL2: remark enable replaces PCP with remark value
// RL3: map mode keeps, ORs, ANDs or replaces map
// RL4: forward map bit n means port n+1
// RL5: count mode reinterprets action field as counter
// RL6: time unit bit selects microseconds or milliseconds
// RL7: timeout mode counts down, interrupt on expiry
// RL8: packet mode increments per match, no timebase
// RL9: terminal count raises interrupt, counter restarts
// RL10: sixteen table entries per port
// RL11: entry fields independent outside count mode
// RL12: count-mode entry uses its own action field
// RL13: filtering actions never raise interrupts
// RL14: per-port interrupt with status and mask
// RL15: global status gated by global port mask; the GSTAT read is pstat_q & pmask_q, only irq_o uses gmask_q
// RL16: rule kind encoding, 01 is L2/counter
// RL17: count match needs MAC and EtherType agree
// RL18: count value packs the filtering control bits
// RL19: matching packet reloads timeout counter
// RL20: status sticky until cleared, output while unmasked
`timescale 1ns/1ns
module acl_action_and_count_logic #(
  parameter int unsigned MS_PERIOD_CYC = acl_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // packet from matching and lookup stages
  input wire logic pkt_valid_i,
  input wire logic [2:0] pkt_port_i,
  input wire logic act_hit_i,
  input wire logic [3:0] act_idx_i,
  input wire logic [2:0] qos_prio_i,
  input wire logic [5:0] lookup_map_i,
  input wire logic [2:0] pcp_i,
  input wire logic cnt_hit_i,
  input wire logic [3:0] cnt_idx_i,
  input wire logic mac_match_i,
  input wire logic type_match_i,
  // action result
  output logic res_valid_o,
  output logic [2:0] res_prio_o,
  output logic [5:0] res_map_o,
  output logic [2:0] res_pcp_o,
  output logic res_remark_o,
  // interrupts
  output logic [5:0] port_irq_o,
  output logic irq_o
);
  localparam int unsigned NP = acl_pkg::NUM_PORTS;
  localparam int unsigned EW = acl_pkg::ENTRY_W;

  logic [EW-1:0] tbl_q [acl_pkg::TBL_DEPTH];
  logic us_tick, ms_tick;
  acl_pkg::acl_cnt_e st_q [NP];
  logic [10:0] cnt_q [NP];
  logic unit_q [NP];
  logic [NP-1:0] evt;

  function automatic logic is_count(input logic [EW-1:0] e);
    is_count = (e[acl_pkg::F_KIND_LO +: 2] == acl_pkg::KIND_L2) &&
               (e[acl_pkg::F_CSEL_LO +: 2] == acl_pkg::CSEL_COUNT); // RL5 RL16
  endfunction : is_count

  acl_timebase #(
    .US_CYC(acl_pkg::US_CYCLES),
    .MS_US(MS_PERIOD_CYC / acl_pkg::US_CYCLES)
  ) u_tb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .us_tick_o(us_tick),
    .ms_tick_o(ms_tick)
  );

  // ---- bus slave
  logic [11:0] addr_q, addr_d;
  logic map_ok_q, map_ok_d, wr_q, wr_d, rd_q, rd_d;
  logic hready_q, hready_d;
  logic [31:0] hrdata_q, hrdata_d, rdata;
  logic [5:0] pstat_q, pstat_d, pmask_q, pmask_d, gmask_q, gmask_d, pclr;
  logic [5:0] port_irq_q;
  logic irq_q, hresp_q;
  logic [11:0] tbl_off;
  logic tbl_hit, tbl_we;
  logic [6:0] tbl_wi;
  logic aphase;

  assign aphase = hsel_i && hready_i && htrans_i[1];
  assign tbl_off = addr_q - acl_pkg::OFS_TABLE;
  assign tbl_hit = map_ok_q && (addr_q >= acl_pkg::OFS_TABLE) &&
                   (tbl_off[11:2] < 10'(acl_pkg::TBL_DEPTH)); // RL10
  assign tbl_wi = tbl_off[8:2];
  assign tbl_we = wr_q && tbl_hit;

  always_comb begin
    rdata = 32'h00000000;
    if (tbl_hit) begin
      rdata = {9'h000, tbl_q[tbl_wi]};
    end else if (map_ok_q) begin
      case (addr_q)
        acl_pkg::OFS_PSTAT: rdata = {26'h0000000, pstat_q};
        acl_pkg::OFS_PMASK: rdata = {26'h0000000, pmask_q};
        acl_pkg::OFS_GSTAT: rdata = {26'h0000000, pstat_q & pmask_q};
        acl_pkg::OFS_GMASK: rdata = {26'h0000000, gmask_q};
        default: rdata = 32'h00000000;
      endcase
      for (int i = 0; i < NP; i++) begin
        if (addr_q == acl_pkg::OFS_CNT_BASE + 12'(i * 4)) begin
          rdata = {21'h000000, cnt_q[i]};
        end
      end
    end
  end

  // reads take one wait state so a write just before is visible
  always_comb begin
    addr_d = addr_q;
    map_ok_d = map_ok_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    hready_d = 1'b1;
    hrdata_d = hrdata_q;
    pmask_d = pmask_q;
    gmask_d = gmask_q;
    pclr = 6'h00;
    if (aphase) begin
      addr_d = {haddr_i[11:2], 2'h0};
      map_ok_d = (haddr_i[31:12] == 20'h00000);
      wr_d = hwrite_i;
      rd_d = !hwrite_i;
      hready_d = hwrite_i;
    end
    if (rd_q) begin
      hrdata_d = rdata;
    end
    if (wr_q && map_ok_q) begin
      case (addr_q)
        acl_pkg::OFS_PSTAT: pclr = hwdata_i[5:0];
        acl_pkg::OFS_PMASK: pmask_d = hwdata_i[5:0];
        acl_pkg::OFS_GMASK: gmask_d = hwdata_i[5:0];
        default: pclr = 6'h00;
      endcase
    end
    pstat_d = (pstat_q & ~pclr) | evt; // RL20 RL14
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_q <= 12'h000;
      map_ok_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
      hresp_q <= 1'b0;
      pstat_q <= acl_pkg::MASK_RST;
      pmask_q <= acl_pkg::MASK_RST;
      gmask_q <= acl_pkg::MASK_RST;
      port_irq_q <= acl_pkg::MASK_RST;
      irq_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      map_ok_q <= map_ok_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      hready_q <= hready_d;
      hrdata_q <= hrdata_d;
      hresp_q <= 1'b0;
      pstat_q <= pstat_d;
      pmask_q <= pmask_d;
      gmask_q <= gmask_d;
      port_irq_q <= pstat_q & pmask_q; // RL14 RL20
      irq_q <= |(pstat_q & pmask_q & gmask_q); // RL15
    end
  end

  // table write is a plain memory port; reset leaves every rule disabled
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < acl_pkg::TBL_DEPTH; i++) begin
        tbl_q[i] <= acl_pkg::TBL_RST;
      end
    end else if (tbl_we) begin
      tbl_q[tbl_wi] <= hwdata_i[EW-1:0];
    end
  end

  // ---- filtering action
  logic [EW-1:0] act_e;
  logic act_filt;
  logic [1:0] act_prio_mode, act_map_mode;
  logic [2:0] act_p, act_rv;
  logic act_remark_en;
  logic [5:0] act_fwd;
  logic res_valid_q, res_valid_d, res_remark_q, res_remark_d;
  logic [2:0] res_prio_q, res_prio_d, res_pcp_q, res_pcp_d;
  logic [5:0] res_map_q, res_map_d;

  assign act_e = (pkt_port_i <= acl_pkg::LAST_PORT) ? tbl_q[{pkt_port_i, act_idx_i}] : acl_pkg::TBL_RST;
  // a count-mode entry's action word holds counter data, never a filter action
  assign act_filt = act_hit_i && !is_count(act_e); // RL11 RL5
  assign act_prio_mode = act_e[acl_pkg::F_PRIO_MODE_LO +: 2];
  assign act_p = act_e[acl_pkg::F_PRIO_LO +: 3];
  assign act_remark_en = act_e[acl_pkg::F_REMARK_EN];
  assign act_rv = act_e[acl_pkg::F_RV_LO +: 3];
  assign act_map_mode = act_e[acl_pkg::F_MAP_MODE_LO +: 2];
  assign act_fwd = act_e[acl_pkg::F_FWD_LO +: 6]; // RL4

  always_comb begin
    res_valid_d = pkt_valid_i;
    res_prio_d = qos_prio_i;
    res_map_d = lookup_map_i;
    res_pcp_d = pcp_i;
    res_remark_d = 1'b0;
    if (pkt_valid_i && act_filt) begin
      case (act_prio_mode)
        acl_pkg::PRIO_QOS: res_prio_d = qos_prio_i; // RL1
        acl_pkg::PRIO_IF_HIGHER: res_prio_d = (act_p > qos_prio_i) ? act_p : qos_prio_i; // RL1
        acl_pkg::PRIO_IF_LOWER: res_prio_d = (act_p < qos_prio_i) ? act_p : qos_prio_i; // RL1
        default: res_prio_d = act_p; // RL1
      endcase
      case (act_map_mode)
        acl_pkg::MAP_KEEP: res_map_d = lookup_map_i; // RL3
        acl_pkg::MAP_OR: res_map_d = lookup_map_i | act_fwd; // RL3
        acl_pkg::MAP_AND: res_map_d = lookup_map_i & act_fwd; // RL3
        default: res_map_d = act_fwd; // RL3
      endcase
      if (act_remark_en) begin
        res_pcp_d = act_rv; // RL2
        res_remark_d = 1'b1; // RL2
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_valid_q <= 1'b0;
      res_prio_q <= 3'h0;
      res_map_q <= 6'h00;
      res_pcp_q <= 3'h0;
      res_remark_q <= 1'b0;
    end else begin
      res_valid_q <= res_valid_d;
      res_prio_q <= res_prio_d;
      res_map_q <= res_map_d;
      res_pcp_q <= res_pcp_d;
      res_remark_q <= res_remark_d;
    end
  end

  // ---- per-port counters; only these set status bits
  logic [NP-1:0] cnt_match;
  for (genvar p = 0; p < NP; p++) begin : g_port
    localparam logic [2:0] PID = 3'(p);
    logic [EW-1:0] ce;
    logic tick, ev;
    logic [10:0] cnt_d, nxt, cval;
    logic unit_d;
    acl_pkg::acl_cnt_e st_d;

    assign ce = tbl_q[{PID, cnt_idx_i}]; // RL12
    assign cval = ce[acl_pkg::F_CNT_LO +: acl_pkg::CNT_W]; // RL18
    assign cnt_match[p] = pkt_valid_i && cnt_hit_i && (pkt_port_i == PID) &&
                          mac_match_i && type_match_i && is_count(ce); // RL17 RL12
    assign tick = unit_q[p] ? ms_tick : us_tick; // RL6

    always_comb begin
      st_d = st_q[p];
      cnt_d = cnt_q[p];
      unit_d = unit_q[p];
      nxt = (st_q[p] == acl_pkg::ACL_CNT_PKT) ? cnt_q[p] + 11'h001 : 11'h001;
      ev = 1'b0;
      case (st_q[p])
        acl_pkg::ACL_CNT_TIME: begin
          if (!cnt_match[p] && tick) begin
            if (cnt_q[p] <= 11'h001) begin
              ev = 1'b1; // RL7
              st_d = acl_pkg::ACL_CNT_IDLE;
              cnt_d = acl_pkg::CNT_RST;
            end else begin
              cnt_d = cnt_q[p] - 11'h001; // RL7
            end
          end
        end
        acl_pkg::ACL_CNT_PKT: st_d = acl_pkg::ACL_CNT_PKT;
        acl_pkg::ACL_CNT_IDLE: st_d = acl_pkg::ACL_CNT_IDLE;
        default: st_d = acl_pkg::ACL_CNT_IDLE;
      endcase
      if (cnt_match[p]) begin
        if (ce[acl_pkg::F_ALGO_SEL]) begin
          st_d = acl_pkg::ACL_CNT_PKT; // RL8
          if (nxt >= cval) begin
            ev = 1'b1; // RL9
            cnt_d = acl_pkg::CNT_RST; // RL9
          end else begin
            cnt_d = nxt; // RL8
          end
        end else begin
          st_d = acl_pkg::ACL_CNT_TIME;
          cnt_d = cval; // RL19 RL7
          unit_d = ce[acl_pkg::F_UNIT_SEL]; // RL6
        end
      end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        st_q[p] <= acl_pkg::ACL_CNT_IDLE;
        cnt_q[p] <= acl_pkg::CNT_RST;
        unit_q[p] <= 1'b0;
      end else begin
        st_q[p] <= st_d;
        cnt_q[p] <= cnt_d;
        unit_q[p] <= unit_d;
      end
    end
    assign evt[p] = ev; // RL13
  end
  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hready_q;
  assign hresp_o = hresp_q;
  assign res_valid_o = res_valid_q;
  assign res_prio_o = res_prio_q;
  assign res_map_o = res_map_q;
  assign res_pcp_o = res_pcp_q;
  assign res_remark_o = res_remark_q;
  assign port_irq_o = port_irq_q;
  assign irq_o = irq_q;
  // ---- checks; counter checks watch the ports that the bench exercises
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd_wait;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  a_prio_always: assert property (pkt_valid_i && act_filt && act_prio_mode == acl_pkg::PRIO_ALWAYS |=> // RL1
    res_prio_o == $past(act_p)) else $error("forced priority not applied");
  a_prio_higher: assert property (pkt_valid_i && act_filt && act_prio_mode == acl_pkg::PRIO_IF_HIGHER && // RL1
    act_p <= qos_prio_i |=> res_prio_o == $past(qos_prio_i)) else $error("lower rule priority applied");
  a_remark_off: assert property (pkt_valid_i && !(act_filt && act_remark_en) |=> // RL2
    res_pcp_o == $past(pcp_i) && !res_remark_o) else $error("pcp changed without remark");
  a_map_and: assert property (pkt_valid_i && act_filt && act_map_mode == acl_pkg::MAP_AND |=> // RL3
    res_map_o == ($past(lookup_map_i) & $past(act_fwd))) else $error("and map wrong");
  a_count_no_filter: assert property (pkt_valid_i && act_hit_i && is_count(act_e) |=> // RL11
    res_map_o == $past(lookup_map_i) && res_prio_o == $past(qos_prio_i)) else $error("count entry filtered");
  a_time_expire: assert property (st_q[2] == acl_pkg::ACL_CNT_TIME && cnt_q[2] == 11'h001 && !cnt_match[2] && // RL7
    (unit_q[2] ? ms_tick : us_tick) |=> st_q[2] == acl_pkg::ACL_CNT_IDLE && pstat_q[2]) else $error("timeout lost");
  a_time_reload: assert property (cnt_match[2] && !g_port[2].ce[acl_pkg::F_ALGO_SEL] |=> // RL19
    st_q[2] == acl_pkg::ACL_CNT_TIME && cnt_q[2] == $past(g_port[2].cval)) else $error("timeout not reloaded");
  a_pkt_terminal: assert property (cnt_match[1] && g_port[1].ce[acl_pkg::F_ALGO_SEL] && // RL9
    g_port[1].nxt >= g_port[1].cval |=> cnt_q[1] == 11'h000 && pstat_q[1]) else $error("terminal count missed");
  a_stat_sticky: assert property (pstat_q[1] && !pclr[1] |=> pstat_q[1]) else $error("status lost"); // RL20
  a_irq_gate: assert property (pstat_q[1] && pmask_q[1] && gmask_q[1] |=> port_irq_o[1] && irq_o) // RL15
    else $error("irq not raised");
  a_no_evt: assert property ((st_q[2] == acl_pkg::ACL_CNT_IDLE && !cnt_match[2]) |-> !evt[2]) // RL13
    else $error("idle event");
  a_rd_wait: assert property (aphase && !hwrite_i |=> s_rd_wait) else $error("read wait state wrong");
endmodule : acl_action_and_count_logic

// ==== acl_far_model.sv ====
`timescale 1ns/1ns
module acl_far_model (
  // clock
  input wire logic clk_i,
  // packet decision fields
  output logic pkt_valid_o,
  output logic [2:0] pkt_port_o,
  output logic act_hit_o,
  output logic [3:0] act_idx_o,
  output logic [2:0] qos_prio_o,
  output logic [5:0] lookup_map_o,
  output logic [2:0] pcp_o,
  output logic cnt_hit_o,
  output logic [3:0] cnt_idx_o,
  output logic mac_match_o,
  output logic type_match_o
);
  initial begin
    {pkt_valid_o, pkt_port_o, act_hit_o, act_idx_o, qos_prio_o} = '0;
    {lookup_map_o, pcp_o, cnt_hit_o, cnt_idx_o, mac_match_o, type_match_o} = '0;
  end

  // one-cycle decision; released port, index, qos, map and pcp fields show the inverse (match flags hold) so stale values never pass as valid
  task automatic send(input logic [2:0] port, input logic act, input logic [3:0] idx, input logic [2:0] qos,
                      input logic [5:0] map, input logic [2:0] pcp, input logic cnt, input logic [3:0] cidx,
                      input logic both);
    @(posedge clk_i);
    pkt_valid_o <= 1'b1;
    pkt_port_o <= port;
    act_hit_o <= act;
    act_idx_o <= idx;
    qos_prio_o <= qos;
    lookup_map_o <= map;
    pcp_o <= pcp;
    cnt_hit_o <= cnt;
    cnt_idx_o <= cidx;
    mac_match_o <= cnt;
    type_match_o <= cnt & both;
    @(posedge clk_i);
    pkt_valid_o <= 1'b0;
    act_hit_o <= 1'b0;
    cnt_hit_o <= 1'b0;
    pkt_port_o <= ~port;
    act_idx_o <= ~idx;
    qos_prio_o <= ~qos;
    lookup_map_o <= ~map;
    pcp_o <= ~pcp;
    cnt_idx_o <= ~cidx;
  endtask : send
endmodule : acl_far_model

// ==== acl_action_and_count_logic_tb_top.sv ====
`timescale 1ns/1ns
module acl_action_and_count_logic_tb_top;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, pv, ah, ch, macm, tm, rv, rr, irq;
  logic [2:0] pp, qp, pc, rpr, rc;
  logic [3:0] ai, ci;
  logic [5:0] lm, rm, pirq;
  int error_cnt = 0, samples_checked = 0, cyc = 0;

  always #50 clk = ~clk;

  acl_far_model far (.clk_i(clk), .pkt_valid_o(pv), .pkt_port_o(pp), .act_hit_o(ah), .act_idx_o(ai),
    .qos_prio_o(qp), .lookup_map_o(lm), .pcp_o(pc), .cnt_hit_o(ch), .cnt_idx_o(ci), .mac_match_o(macm),
    .type_match_o(tm));

  acl_action_and_count_logic #(.MS_PERIOD_CYC(100)) dut (.clk_i(clk), .rst_i(rst), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .pkt_valid_i(pv),
    .pkt_port_i(pp), .act_hit_i(ah), .act_idx_i(ai), .qos_prio_i(qp), .lookup_map_i(lm), .pcp_i(pc),
    .cnt_hit_i(ch), .cnt_idx_i(ci), .mac_match_i(macm), .type_match_i(tm), .res_valid_o(rv),
    .res_prio_o(rpr), .res_map_o(rm), .res_pcp_o(rc), .res_remark_o(rr), .port_irq_o(pirq), .irq_o(irq));

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // outputs are registered, so the value at a falling edge is what the next rising edge samples
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    logic rdy;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      @(negedge clk);
      rdy = hreadyout;
      @(posedge clk);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      @(negedge clk);
      rdy = hreadyout;
      r = hrdata;
      @(posedge clk);
    end
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
    chk(32'(hresp), 32'h0);
  endtask : rd

  function automatic logic [31:0] ta(input logic [2:0] p, input logic [3:0] e);
    ta = 32'h100 + {23'h0, p, e, 2'h0};
  endfunction : ta

  function automatic logic [31:0] cent(input logic unit, input logic algo, input logic [10:0] n);
    cent = {9'h0, 2'h0, 2'h1, 6'h00, algo, unit, n};
  endfunction : cent

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic t_regs;
    rd(32'h4, 32'h0);
    rd(32'hC, 32'h0);
    wr(32'h1000, 32'hFFFFFFFF);
    rd(32'h1000, 32'h0);
    wr(ta(3'h5, 4'hF), 32'hFFFFFFFF);
    rd(ta(3'h5, 4'hF), 32'h007FFFFF);
    $display("test regs done");
  endtask : t_regs

  task automatic t_filter;
    logic [2:0] q, ep;
    logic [5:0] em;
    for (int i = 0; i < 8; i++) begin
      q = i[2] ? 3'h5 : 3'h3;
      // matching kind left disabled: the action still applies on its own
      // forward map 0x0F in bits 18:13 so OR, AND and replace each change the lookup map
      wr(ta(3'h3, 4'(i)), {13'h0, 6'h0F, 2'h0, i[1:0], 3'h6, i[0], 3'h4, i[1:0]});
      far.send(3'h3, 1'b1, 4'(i), q, 6'h2A, 3'h1, 1'b0, 4'h0, 1'b0);
      @(negedge clk);
      case (i[1:0])
        2'h0: ep = q;
        2'h1: ep = (3'h4 > q) ? 3'h4 : q;
        2'h2: ep = (3'h4 < q) ? 3'h4 : q;
        default: ep = 3'h4;
      endcase
      em = (i[1:0] == 2'h0) ? 6'h2A : (i[1:0] == 2'h1) ? 6'h2F : (i[1:0] == 2'h2) ? 6'h0A : 6'h0F;
      chk(32'({rv, rr, rc, rm, rpr}), 32'({1'b1, i[0], i[0] ? 3'h6 : 3'h1, em, ep}));
    end
    wr(ta(3'h3, 4'h8), cent(1'b0, 1'b1, 11'h7FF));
    far.send(3'h3, 1'b1, 4'h8, 3'h5, 6'h2A, 3'h1, 1'b0, 4'h0, 1'b0);
    @(negedge clk);
    chk(32'({rv, rr, rm, rpr}), 32'({1'b1, 1'b0, 6'h2A, 3'h5}));
    rd(32'h0, 32'h0);
    $display("test filter done");
  endtask : t_filter

  task automatic t_pktcnt;
    wr(32'h4, 32'h2);
    wr(32'hC, 32'h2);
    wr(ta(3'h1, 4'h2), cent(1'b0, 1'b1, 11'h003));
    repeat (2) far.send(3'h1, 1'b0, 4'h0, 3'h0, 6'h0, 3'h0, 1'b1, 4'h2, 1'b1);
    far.send(3'h1, 1'b0, 4'h0, 3'h0, 6'h0, 3'h0, 1'b1, 4'h2, 1'b0);
    rd(32'h24, 32'h2);
    settle(1);
    chk(32'({irq, pirq}), 32'h0);
    far.send(3'h1, 1'b0, 4'h0, 3'h0, 6'h0, 3'h0, 1'b1, 4'h2, 1'b1);
    settle(3);
    chk(32'({irq, pirq}), 32'h42);
    rd(32'h0, 32'h2);
    rd(32'h8, 32'h2);
    rd(32'h24, 32'h0);
    wr(32'hC, 32'h0);
    settle(3);
    chk(32'({irq, pirq}), 32'h02);
    wr(32'h0, 32'h2);
    settle(3);
    chk(32'({irq, pirq}), 32'h0);
    far.send(3'h1, 1'b0, 4'h0, 3'h0, 6'h0, 3'h0, 1'b1, 4'h2, 1'b1);
    rd(32'h24, 32'h1);
    $display("test packet count done");
  endtask : t_pktcnt

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (pirq[2] !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(32'(pirq[2]), 32'h1);
    wr(32'h0, 32'h4);
  endtask : wait_irq

  task automatic t_timeout;
    wr(32'h4, 32'h4);
    // a unit can start short since the timebase free-runs, so early checks come before the count less one unit has passed
    wr(ta(3'h2, 4'h0), cent(1'b1, 1'b0, 11'h002));
    far.send(3'h2, 1'b0, 4'h0, 3'h0, 6'h0, 3'h0, 1'b1, 4'h0, 1'b1);
    settle(95);
    chk(32'(pirq[2]), 32'h0);
    far.send(3'h2, 1'b0, 4'h0, 3'h0, 6'h0, 3'h0, 1'b1, 4'h0, 1'b1);
    settle(95);
    chk(32'(pirq[2]), 32'h0);
    wait_irq(250);
    wr(ta(3'h2, 4'h0), cent(1'b0, 1'b0, 11'h005));
    far.send(3'h2, 1'b0, 4'h0, 3'h0, 6'h0, 3'h0, 1'b1, 4'h0, 1'b1);
    settle(30);
    chk(32'(pirq[2]), 32'h0);
    wait_irq(70);
    $display("test timeout done");
  endtask : t_timeout

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_filter();
    t_pktcnt();
    t_timeout();
    final_report();
  end
endmodule : acl_action_and_count_logic_tb_top
